//--- logic/od_pkg.sv
// Object indices, sub-entry values, limits and delivery values of the dictionary.
package od_pkg;
  localparam logic [15:0] IDX_DEV_TYPE = 16'h1000;
  localparam logic [15:0] IDX_ERR_REG = 16'h1001;
  localparam logic [15:0] IDX_ERR_HIST = 16'h1003;
  localparam logic [15:0] IDX_SW_VER = 16'h100a;
  localparam logic [15:0] IDX_IDENTITY = 16'h1018;
  localparam logic [15:0] IDX_RX_COMM = 16'h1400;
  localparam logic [15:0] IDX_RX_MAP = 16'h1600;
  localparam logic [15:0] IDX_TX_COMM = 16'h1800;
  localparam logic [15:0] IDX_TX_MAP = 16'h1a00;
  localparam logic [15:0] IDX_GOAL = 16'h2001;
  localparam logic [15:0] IDX_CURRENT = 16'h2003;
  localparam logic [15:0] IDX_OFFSET = 16'h2004;
  localparam logic [15:0] IDX_FERR_LIM = 16'h2005;
  localparam logic [15:0] IDX_WINDOW = 16'h2006;
  localparam logic [15:0] IDX_SCALE_NUM = 16'h2010;
  localparam logic [15:0] IDX_SCALE_DEN = 16'h2011;
  localparam logic [15:0] IDX_SPD_POS = 16'h2012;
  localparam logic [15:0] IDX_SPD_MAN = 16'h2013;
  localparam logic [15:0] IDX_TRQ_RUN = 16'h2014;
  localparam logic [15:0] IDX_TRQ_START = 16'h2018;
  localparam logic [15:0] IDX_CONTROL = 16'h2024;
  localparam logic [15:0] IDX_STATUS = 16'h2025;
  localparam logic [63:0] RX_MAP_1 = 64'h0010_0000_0000_2024;
  localparam logic [63:0] RX_MAP_2 = 64'h0020_0010_0000_2001;
  localparam logic [63:0] TX_MAP_1 = 64'h0010_0000_0000_2025;
  localparam logic [63:0] TX_MAP_2 = 64'h0010_0010_0000_2030;
  localparam logic [63:0] TX_MAP_3 = 64'h0020_0020_0000_2003;
  localparam logic [7:0] RX_MAP_CNT = 8'h02;
  localparam logic [7:0] TX_MAP_CNT = 8'h03;
  localparam logic [7:0] COMM_CNT = 8'h02;
  localparam logic [7:0] ID_CNT = 8'h04;
  localparam int HIST_DEPTH = 254;
  localparam logic [7:0] HIST_MAX = 8'hfe;
  localparam logic [15:0] FERR_MAX = 16'h03e8;
  localparam logic [15:0] WIN_MIN = 16'h0001;
  localparam logic [15:0] WIN_MAX = 16'h0064;
  localparam logic [15:0] SCALE_MIN = 16'h0001;
  localparam logic [15:0] SCALE_MAX = 16'h2710;
  localparam logic [15:0] FERR_RST = 16'h0000;
  localparam logic [15:0] WIN_RST = 16'h0002;
  localparam logic [15:0] SCALE_RST = 16'h0190;
  localparam logic [15:0] SPD_POS_RST = 16'h0064;
  localparam logic [15:0] SPD_MAN_RST = 16'h0032;
  localparam logic [15:0] TRQ_RUN_RST = 16'h0064;
  localparam logic [15:0] TRQ_START_RST = 16'h0064;
  localparam int CW_MAN_UP = 0;
  localparam int CW_MAN_DN = 1;
  localparam int CW_TRANSFER = 2;
  localparam int CW_RELEASE = 4;
  localparam int SW_REACHED = 0;
  localparam int SW_FERR = 1;
  localparam int RX_CW_LSB = 0;
  localparam int RX_GOAL_LSB = 16;
  localparam int TX_AUX_LSB = 16;
  localparam int TX_ACT_LSB = 32;
endpackage

//--- logic/drive_object_dictionary.sv
// Object dictionary of the positioning drive with service and process data access.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Device type object always reads zero, 32 bits, read-only.
// - Read-only 8-bit error register with generic-error bit in bit 0.
// - Error history: clearable count, 254 entries, newest at sub one.
// - Identity reports 4 entries: vendor, product, revision, serial, read-only.
// - Receive mapping: control word, then 32-bit target at bit 16.
// - Transmit mapping: status word, object 2030, actual position; count 3.
// - Communication objects report 2; node id writable, default 0; version 0.
// - Signed 32-bit target, default zero, cleared at power-on.
// - Writing actual position re-references the axle onto the written value.
// - Reference, offset, window and scaling writes only at standstill.
// - Retained signed offset corrects target and actual values.
// - Following error flagged when lag exceeds nonzero 16-bit limit, max 1000; limit 0 disables it.
// - Position reached only inside window, default 2, max 100.
// - Scaling numerator and denominator up to 10000, default 400.
// - Separate retained speed limits for positioning and manual runs.
// - Start-up torque limit in start phase, running limit afterwards.
// - Control bit 4 releases the axle; no motion while clear.
// - Status word bit 0 reached, bit 1 following error.
module drive_object_dictionary
  import od_pkg::*;
#(
  parameter logic [31:0] VENDOR_ID = 32'h0000_0001,
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0002,
  parameter logic [31:0] REVISION = 32'h0000_0003,
  parameter logic [31:0] SERIAL_NO = 32'h0000_0004,
  parameter logic [63:0] SW_VERSION = 64'h0044_5249_5645_3031
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic comm_reset_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [15:0] req_index_i,
  input wire logic [7:0] req_sub_i,
  input wire logic [63:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_refused_o,
  output logic [63:0] rsp_rdata_o,
  input wire logic pdo_rx_valid_i,
  input wire logic [47:0] pdo_rx_data_i,
  output logic [63:0] pdo_tx_data_o,
  input wire logic [31:0] mech_pos_i,
  input wire logic [31:0] traj_pos_i,
  input wire logic standstill_i,
  input wire logic start_phase_i,
  input wire logic [15:0] aux_word_i,
  input wire logic [7:0] err_flags_i,
  input wire logic err_event_i,
  input wire logic [31:0] err_code_i,
  output logic motion_enable_o,
  output logic [31:0] cmd_target_o,
  output logic [15:0] scale_num_o,
  output logic [15:0] scale_den_o,
  output logic [15:0] speed_limit_o,
  output logic [15:0] torque_limit_o,
  output logic position_reached_o,
  output logic following_error_o
);

  logic [31:0] goal_reg, shift_reg, offset_reg;
  logic [15:0] ctrl_reg, ferr_lim_reg, window_reg, num_reg, den_reg;
  logic [15:0] spd_pos_reg, spd_man_reg, trq_run_reg, trq_start_reg;
  logic [7:0] rx_node_reg, tx_node_reg, err_reg, hist_cnt_reg, hist_cnt_next;
  logic [31:0] hist_reg [0:HIST_DEPTH-1];
  logic rd_hit;
  logic [63:0] rd_data;

  wire logic is_wr = req_valid_i & req_write_i;
  wire logic is_rd = req_valid_i & ~req_write_i;
  wire logic s0 = req_sub_i == 8'h00;
  wire logic [15:0] w16 = req_wdata_i[15:0];
  wire logic [31:0] w32 = req_wdata_i[31:0];
  wire logic w16_scale = (w16 >= SCALE_MIN) && (w16 <= SCALE_MAX);

  // Object writes, qualified where needed by their range and by standstill.
  wire logic wr_goal = is_wr && req_index_i == IDX_GOAL && s0;
  wire logic wr_cur = is_wr && req_index_i == IDX_CURRENT && s0 &&
                      standstill_i;
  wire logic wr_off = is_wr && req_index_i == IDX_OFFSET && s0 &&
                      standstill_i;
  wire logic wr_ferr = is_wr && req_index_i == IDX_FERR_LIM && s0 &&
                       w16 <= FERR_MAX;
  wire logic wr_win = is_wr && req_index_i == IDX_WINDOW && s0 &&
                      standstill_i && w16 >= WIN_MIN && w16 <= WIN_MAX;
  wire logic wr_num = is_wr && req_index_i == IDX_SCALE_NUM && s0 &&
                      standstill_i && w16_scale;
  wire logic wr_den = is_wr && req_index_i == IDX_SCALE_DEN && s0 &&
                      standstill_i && w16_scale;
  wire logic wr_spd_pos = is_wr && req_index_i == IDX_SPD_POS && s0;
  wire logic wr_spd_man = is_wr && req_index_i == IDX_SPD_MAN && s0;
  wire logic wr_trq_run = is_wr && req_index_i == IDX_TRQ_RUN && s0;
  wire logic wr_trq_start = is_wr && req_index_i == IDX_TRQ_START && s0;
  wire logic wr_ctrl = is_wr && req_index_i == IDX_CONTROL && s0;
  wire logic wr_hist = is_wr && req_index_i == IDX_ERR_HIST && s0 &&
                       w16 == 16'h0000;
  wire logic wr_rx_node = is_wr && req_index_i == IDX_RX_COMM &&
                          req_sub_i == 8'h01;
  wire logic wr_tx_node = is_wr && req_index_i == IDX_TX_COMM &&
                          req_sub_i == 8'h01;
  // Mapping counts are writable but only with their fixed value.
  wire logic wr_map_cnt = is_wr && s0 &&
    ((req_index_i == IDX_RX_MAP && w16 == {8'h00, RX_MAP_CNT}) ||
     (req_index_i == IDX_TX_MAP && w16 == {8'h00, TX_MAP_CNT}));
  wire logic wr_ok = wr_goal | wr_cur | wr_off | wr_ferr | wr_win | wr_num |
                     wr_den | wr_spd_pos | wr_spd_man | wr_trq_run |
                     wr_trq_start | wr_ctrl | wr_hist | wr_rx_node |
                     wr_tx_node | wr_map_cnt;

  wire logic pdo_goal = pdo_rx_valid_i & pdo_rx_data_i[RX_CW_LSB + CW_TRANSFER];
  wire logic goal_load = pdo_goal | wr_goal;
  wire logic [31:0] actual_user = mech_pos_i - shift_reg + offset_reg;
  wire logic [32:0] pos_diff = {goal_reg[31], goal_reg} -
                               {actual_user[31], actual_user};
  wire logic [32:0] pos_dist = pos_diff[32] ? 33'(-pos_diff) : pos_diff;
  wire logic [32:0] lag_diff = {traj_pos_i[31], traj_pos_i} -
                               {mech_pos_i[31], mech_pos_i};
  wire logic [32:0] lag_dist = lag_diff[32] ? 33'(-lag_diff) : lag_diff;
  wire logic reached_next = pos_dist <= {17'h0_0000, window_reg};
  wire logic ferr_next = (ferr_lim_reg != 16'h0000) &&
                         lag_dist > {17'h0_0000, ferr_lim_reg};
  wire logic [15:0] status_word = {14'h0000, following_error_o,
                                   position_reached_o};
  wire logic manual_run = ctrl_reg[CW_MAN_UP] | ctrl_reg[CW_MAN_DN];
  wire logic [7:0] hist_sel = req_sub_i - 8'h01;
  wire logic hist_full = hist_cnt_reg == HIST_MAX;

  // Read selection; an object or sub-index not listed is refused.
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 64'h0;
    case (req_index_i)
      IDX_DEV_TYPE: rd_hit = s0;
      IDX_ERR_REG: begin
        rd_hit = s0;
        rd_data = {56'h0, err_reg};
      end
      IDX_ERR_HIST: begin
        if (s0) begin
          rd_data = {56'h0, hist_cnt_reg};
        end else if (req_sub_i <= hist_cnt_reg) begin
          rd_data = {32'h0, hist_reg[hist_sel]};
        end else begin
          rd_hit = 1'b0;
        end
      end
      IDX_SW_VER: begin
        rd_hit = s0;
        rd_data = SW_VERSION;
      end
      IDX_IDENTITY: begin
        case (req_sub_i)
          8'h00: rd_data = {56'h0, ID_CNT};
          8'h01: rd_data = {32'h0, VENDOR_ID};
          8'h02: rd_data = {32'h0, PRODUCT_CODE};
          8'h03: rd_data = {32'h0, REVISION};
          8'h04: rd_data = {32'h0, SERIAL_NO};
          default: rd_hit = 1'b0;
        endcase
      end
      IDX_RX_COMM, IDX_TX_COMM: begin
        case (req_sub_i)
          8'h00: rd_data = {56'h0, COMM_CNT};
          8'h01: rd_data = {56'h0, (req_index_i == IDX_RX_COMM) ?
                            rx_node_reg : tx_node_reg};
          8'h02: rd_data = 64'h0;
          default: rd_hit = 1'b0;
        endcase
      end
      IDX_RX_MAP: begin
        case (req_sub_i)
          8'h00: rd_data = {56'h0, RX_MAP_CNT};
          8'h01: rd_data = RX_MAP_1;
          8'h02: rd_data = RX_MAP_2;
          default: rd_hit = 1'b0;
        endcase
      end
      IDX_TX_MAP: begin
        case (req_sub_i)
          8'h00: rd_data = {56'h0, TX_MAP_CNT};
          8'h01: rd_data = TX_MAP_1;
          8'h02: rd_data = TX_MAP_2;
          8'h03: rd_data = TX_MAP_3;
          default: rd_hit = 1'b0;
        endcase
      end
      IDX_GOAL: rd_data = {32'h0, goal_reg};
      IDX_CURRENT: rd_data = {32'h0, actual_user};
      IDX_OFFSET: rd_data = {32'h0, offset_reg};
      IDX_FERR_LIM: rd_data = {48'h0, ferr_lim_reg};
      IDX_WINDOW: rd_data = {48'h0, window_reg};
      IDX_SCALE_NUM: rd_data = {48'h0, num_reg};
      IDX_SCALE_DEN: rd_data = {48'h0, den_reg};
      IDX_SPD_POS: rd_data = {48'h0, spd_pos_reg};
      IDX_SPD_MAN: rd_data = {48'h0, spd_man_reg};
      IDX_TRQ_RUN: rd_data = {48'h0, trq_run_reg};
      IDX_TRQ_START: rd_data = {48'h0, trq_start_reg};
      IDX_CONTROL: rd_data = {48'h0, ctrl_reg};
      IDX_STATUS: rd_data = {48'h0, status_word};
      default: rd_hit = 1'b0;
    endcase
    if (!s0 && req_index_i[15:12] == 4'h2) begin
      rd_hit = 1'b0;
    end
  end

  // Every request is answered one cycle later.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_refused_o <= 1'b0;
      rsp_rdata_o <= 64'h0;
    end else begin
      rsp_valid_o <= req_valid_i;
      rsp_refused_o <= req_valid_i & (req_write_i ? ~wr_ok : ~rd_hit);
      rsp_rdata_o <= (is_rd & rd_hit) ? rd_data : 64'h0;
    end
  end

  // Objects that are not backed up return to delivery state on reset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      goal_reg <= 32'h0;
      ctrl_reg <= 16'h0;
      shift_reg <= 32'h0;
      rx_node_reg <= 8'h00;
      tx_node_reg <= 8'h00;
    end else if (comm_reset_i) begin
      goal_reg <= 32'h0;
      ctrl_reg <= 16'h0;
      shift_reg <= 32'h0;
      rx_node_reg <= 8'h00;
      tx_node_reg <= 8'h00;
    end else begin
      if (pdo_goal) begin
        goal_reg <= pdo_rx_data_i[RX_GOAL_LSB +: 32];
      end else if (wr_goal) begin
        goal_reg <= w32;
      end
      if (pdo_rx_valid_i) begin
        ctrl_reg <= pdo_rx_data_i[RX_CW_LSB +: 16] &
                    {14'h3fff, {2{~pdo_goal}}};
      end else if (wr_ctrl) begin
        ctrl_reg <= w16;
      end else if (goal_load) begin
        ctrl_reg <= ctrl_reg & 16'hfffc;
      end
      if (wr_cur) begin
        shift_reg <= mech_pos_i + offset_reg - w32;
      end
      if (wr_rx_node) begin
        rx_node_reg <= req_wdata_i[7:0];
      end
      if (wr_tx_node) begin
        tx_node_reg <= req_wdata_i[7:0];
      end
    end
  end

  // Backed-up parameters keep their value across communication resets.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offset_reg <= 32'h0;
      ferr_lim_reg <= FERR_RST;
      window_reg <= WIN_RST;
      num_reg <= SCALE_RST;
      den_reg <= SCALE_RST;
      spd_pos_reg <= SPD_POS_RST;
      spd_man_reg <= SPD_MAN_RST;
      trq_run_reg <= TRQ_RUN_RST;
      trq_start_reg <= TRQ_START_RST;
    end else begin
      if (wr_off) offset_reg <= w32;
      if (wr_ferr) ferr_lim_reg <= w16;
      if (wr_win) window_reg <= w16;
      if (wr_num) num_reg <= w16;
      if (wr_den) den_reg <= w16;
      if (wr_spd_pos) spd_pos_reg <= w16;
      if (wr_spd_man) spd_man_reg <= w16;
      if (wr_trq_run) trq_run_reg <= w16;
      if (wr_trq_start) trq_start_reg <= w16;
    end
  end

  // A new error in the clearing cycle is kept as the only entry.
  always_comb begin
    hist_cnt_next = hist_cnt_reg;
    if (wr_hist | comm_reset_i) begin
      hist_cnt_next = err_event_i ? 8'h01 : 8'h00;
    end else if (err_event_i && !hist_full) begin
      hist_cnt_next = hist_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist_cnt_reg <= 8'h00;
      err_reg <= 8'h00;
    end else begin
      hist_cnt_reg <= hist_cnt_next;
      err_reg <= {err_flags_i[7:1], |err_flags_i};
    end
  end

  // Newest error enters entry zero and older ones move one place up.
  genvar g;
  generate
    for (g = 0; g < HIST_DEPTH; g++) begin : g_hist
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          hist_reg[g] <= 32'h0;
        end else if (err_event_i) begin
          hist_reg[g] <= (g == 0) ? err_code_i : hist_reg[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  // Motion-facing and process data outputs.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      motion_enable_o <= 1'b0;
      cmd_target_o <= 32'h0;
      scale_num_o <= SCALE_RST;
      scale_den_o <= SCALE_RST;
      speed_limit_o <= SPD_POS_RST;
      torque_limit_o <= TRQ_START_RST;
      position_reached_o <= 1'b0;
      following_error_o <= 1'b0;
      pdo_tx_data_o <= 64'h0;
    end else begin
      motion_enable_o <= ctrl_reg[CW_RELEASE];
      cmd_target_o <= goal_reg - offset_reg + shift_reg;
      scale_num_o <= num_reg;
      scale_den_o <= den_reg;
      speed_limit_o <= manual_run ? spd_man_reg : spd_pos_reg;
      torque_limit_o <= start_phase_i ? trq_start_reg : trq_run_reg;
      position_reached_o <= reached_next;
      following_error_o <= ferr_next;
      pdo_tx_data_o <= {actual_user, aux_word_i, status_word};
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ro_write;
    is_wr && (req_index_i == IDX_DEV_TYPE || req_index_i == IDX_STATUS);
  endsequence
  property p_ro_refused;
    s_ro_write |=> rsp_valid_o && rsp_refused_o && rsp_rdata_o == 64'h0;
  endproperty
  a_ro_refused: assert property (p_ro_refused)
    else $error("write to read-only object not refused");

  property p_dev_type_zero;
    is_rd && req_index_i == IDX_DEV_TYPE && s0
      |=> !rsp_refused_o && rsp_rdata_o == 64'h0;
  endproperty
  a_dev_type_zero: assert property (p_dev_type_zero)
    else $error("device type did not read zero");

  property p_ident_count;
    is_rd && req_index_i == IDX_IDENTITY && s0 |=> rsp_rdata_o == 64'h4;
  endproperty
  a_ident_count: assert property (p_ident_count)
    else $error("identity count not four");

  sequence s_err_push;
    err_event_i && !hist_full && !wr_hist && !comm_reset_i;
  endsequence
  property p_hist_push;
    s_err_push |=> hist_cnt_reg == $past(hist_cnt_reg) + 8'h01 &&
                   hist_reg[0] == $past(err_code_i);
  endproperty
  a_hist_push: assert property (p_hist_push)
    else $error("error entry not placed at sub one");

  sequence s_ref_write;
    wr_cur ##1 ($stable(mech_pos_i) && !req_valid_i && !comm_reset_i);
  endsequence
  property p_reference;
    s_ref_write |=> pdo_tx_data_o[TX_ACT_LSB +: 32] ==
                    $past(req_wdata_i[31:0], 2);
  endproperty
  a_reference: assert property (p_reference)
    else $error("actual value not re-referenced to written value");

  property p_moving_refused;
    is_wr && req_index_i == IDX_WINDOW && !standstill_i |=> rsp_refused_o;
  endproperty
  a_moving_refused: assert property (p_moving_refused)
    else $error("window write accepted while moving");

  property p_scale_range;
    is_wr && req_index_i == IDX_SCALE_NUM && (w16 == 16'h0 ||
      w16 > SCALE_MAX) |=> rsp_refused_o && $stable(num_reg);
  endproperty
  a_scale_range: assert property (p_scale_range)
    else $error("out-of-range scaling accepted");

  property p_ferr_off;
    ferr_lim_reg == 16'h0 ##1 ferr_lim_reg == 16'h0 |-> !following_error_o;
  endproperty
  a_ferr_off: assert property (p_ferr_off)
    else $error("following error with zero limit");

  property p_release;
    !ctrl_reg[CW_RELEASE] |=> !motion_enable_o;
  endproperty
  a_release: assert property (p_release)
    else $error("motion enabled without release");

  property p_rx_goal;
    pdo_goal && !comm_reset_i |=> goal_reg == $past(pdo_rx_data_i[47:16]);
  endproperty
  a_rx_goal: assert property (p_rx_goal)
    else $error("target not taken from bit 16 of receive data");

  property p_status_bits;
    ##1 pdo_tx_data_o[SW_REACHED] == $past(position_reached_o) &&
        pdo_tx_data_o[SW_FERR] == $past(following_error_o);
  endproperty
  a_status_bits: assert property (p_status_bits)
    else $error("status word bits do not follow flags");

endmodule // drive_object_dictionary
`default_nettype wire

//--- dv/od_node_model.sv
// Managing node model issuing object requests and process data frames.
`timescale 1ns/1ps
`default_nettype none
module od_node_model (
  input wire logic mclk_i,
  input wire logic rsp_valid_i,
  input wire logic rsp_refused_i,
  input wire logic [63:0] rsp_rdata_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic [15:0] req_index_o,
  output logic [7:0] req_sub_o,
  output logic [63:0] req_wdata_o,
  output logic pdo_rx_valid_o,
  output logic [47:0] pdo_rx_data_o
);
  initial begin
    {req_valid_o, pdo_rx_valid_o, pdo_rx_data_o} = '0;
    {req_write_o, req_index_o, req_sub_o, req_wdata_o} = '0;
  end
  // Released fields show the inverse of the last value.
  task automatic access(input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [63:0] d,
      output logic v, output logic r, output logic [63:0] q);
    @(negedge mclk_i);
    req_valid_o = 1'b1;
    {req_write_o, req_index_o, req_sub_o, req_wdata_o} = {w, i, s, d};
    @(negedge mclk_i);
    v = rsp_valid_i;
    r = rsp_refused_i;
    q = rsp_rdata_i;
    req_valid_o = 1'b0;
    {req_write_o, req_index_o, req_sub_o, req_wdata_o} = ~{w, i, s, d};
  endtask
  task automatic send(input logic [15:0] cw, input logic [31:0] t);
    @(negedge mclk_i);
    pdo_rx_valid_o = 1'b1;
    pdo_rx_data_o = {t, cw};
    @(negedge mclk_i);
    pdo_rx_valid_o = 1'b0;
    pdo_rx_data_o = ~{t, cw};
  endtask
endmodule // od_node_model
`default_nettype wire

//--- dv/drive_object_dictionary_tb.sv
// Self-checking bench for the drive object dictionary.
`timescale 1ns/1ps
`default_nettype none
module drive_object_dictionary_tb;
  import od_pkg::*;
  logic mclk_i, rst_n_i, comm_reset_i, req_valid_i, req_write_i, got_v;
  logic rsp_valid_o, rsp_refused_o, pdo_rx_valid_i, standstill_i, got_r;
  logic start_phase_i, err_event_i, motion_enable_o;
  logic position_reached_o, following_error_o;
  logic [7:0] req_sub_i, err_flags_i;
  logic [15:0] req_index_i, aux_word_i, scale_num_o, scale_den_o;
  logic [15:0] speed_limit_o, torque_limit_o;
  logic [31:0] mech_pos_i, traj_pos_i, err_code_i, cmd_target_o;
  logic [47:0] pdo_rx_data_i;
  logic [63:0] req_wdata_i, rsp_rdata_o, pdo_tx_data_o, got_d;
  int err_count, total_checks;
  // Arbitrary vendor value.
  drive_object_dictionary #(.VENDOR_ID(32'h0000_5a5a)) DUT (
    .mclk_i, .rst_n_i, .comm_reset_i, .req_valid_i, .req_write_i,
    .req_index_i, .req_sub_i, .req_wdata_i, .rsp_valid_o, .rsp_refused_o,
    .rsp_rdata_o, .pdo_rx_valid_i, .pdo_rx_data_i, .pdo_tx_data_o,
    .mech_pos_i, .traj_pos_i, .standstill_i, .start_phase_i, .aux_word_i,
    .err_flags_i, .err_event_i, .err_code_i, .motion_enable_o,
    .cmd_target_o, .scale_num_o, .scale_den_o, .speed_limit_o,
    .torque_limit_o, .position_reached_o, .following_error_o);
  od_node_model node (.mclk_i, .rsp_valid_i(rsp_valid_o),
    .rsp_refused_i(rsp_refused_o), .rsp_rdata_i(rsp_rdata_o),
    .req_valid_o(req_valid_i), .req_write_o(req_write_i),
    .req_index_o(req_index_i), .req_sub_o(req_sub_i),
    .req_wdata_o(req_wdata_i), .pdo_rx_valid_o(pdo_rx_valid_i),
    .pdo_rx_data_o(pdo_rx_data_i));
  task automatic chk(input string n, input logic [65:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input string n, input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [63:0] d, input logic r,
      input logic [63:0] e);
    node.access(w, i, s, d, got_v, got_r, got_d);
    chk(n, {got_v, got_r, got_d}, {1'b1, r, e});
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge mclk_i);
  endtask
  task automatic t_defaults;
    chk("num_o", scale_num_o, 400);
    acc("dtype", 0, IDX_DEV_TYPE, 0, 0, 0, 0);
    acc("hcnt", 0, IDX_ERR_HIST, 0, 0, 0, 0);
    acc("idcnt", 0, IDX_IDENTITY, 0, 0, 0, 4);
    acc("vend", 0, IDX_IDENTITY, 1, 0, 0, 64'h5a5a);
    acc("rxcnt", 0, IDX_RX_MAP, 0, 0, 0, 2);
    acc("rxm2", 0, IDX_RX_MAP, 2, 0, 0, 64'h0020001000002001);
    acc("txcnt", 0, IDX_TX_MAP, 0, 0, 0, 3);
    acc("txm2", 0, IDX_TX_MAP, 2, 0, 0, 64'h0010001000002030);
    acc("rxcom", 0, IDX_RX_COMM, 0, 0, 0, 2);
    acc("txver", 0, IDX_TX_COMM, 2, 0, 0, 0);
    acc("goal", 0, IDX_GOAL, 0, 0, 0, 0);
    acc("ofs", 0, IDX_OFFSET, 0, 0, 0, 0);
    acc("ferr", 0, IDX_FERR_LIM, 0, 0, 0, 0);
    acc("win", 0, IDX_WINDOW, 0, 0, 0, 2);
    acc("den", 0, IDX_SCALE_DEN, 0, 0, 0, 400);
  endtask
  task automatic t_protect;
    acc("dt_w", 1, IDX_DEV_TYPE, 0, 5, 1, 0);
    acc("dt_r", 0, IDX_DEV_TYPE, 0, 0, 0, 0);
    acc("id_w", 1, IDX_IDENTITY, 1, 7, 1, 0);
    acc("map_w", 1, IDX_RX_MAP, 1, 0, 1, 0);
    acc("ver_w", 1, IDX_RX_COMM, 2, 1, 1, 0);
    acc("node_w", 1, IDX_TX_COMM, 1, 9, 0, 0);
    acc("node_r", 0, IDX_TX_COMM, 1, 0, 0, 9);
    acc("unk", 0, 16'h3000, 0, 0, 1, 0);
  endtask
  task automatic t_limits;
    standstill_i = 1'b0;
    acc("ofs_mv", 1, IDX_OFFSET, 0, 3, 1, 0);
    standstill_i = 1'b1;
    acc("ofs_ss", 1, IDX_OFFSET, 0, 0, 0, 0);
    acc("fe_hi", 1, IDX_FERR_LIM, 0, 1001, 1, 0);
    acc("fe_ok", 1, IDX_FERR_LIM, 0, 10, 0, 0);
    acc("w_lo", 1, IDX_WINDOW, 0, 0, 1, 0);
    acc("w_hi", 1, IDX_WINDOW, 0, 101, 1, 0);
    acc("w_ok", 1, IDX_WINDOW, 0, 100, 0, 0);
    acc("w_2", 1, IDX_WINDOW, 0, 2, 0, 0);
    acc("d_hi", 1, IDX_SCALE_DEN, 0, 10001, 1, 0);
    acc("d_ok", 1, IDX_SCALE_DEN, 0, 10000, 0, 0);
    step(2);
    chk("den_o", scale_den_o, 10000);
  endtask
  task automatic t_motion;
    {mech_pos_i, traj_pos_i} = {32'd98, 32'd108};
    node.send(16'h0014, 100);
    step(3);
    chk("en", motion_enable_o, 1);
    chk("reach", {position_reached_o, pdo_tx_data_o[0]}, 2'b11);
    chk("aux", pdo_tx_data_o[31:16], aux_word_i);
    chk("cmd", cmd_target_o, 32'd100);
    chk("fe10", following_error_o, 0);
    traj_pos_i = 109;
    step(3);
    chk("fe11", {following_error_o, pdo_tx_data_o[1]}, 2'b11);
    mech_pos_i = 97;
    step(3);
    chk("miss", position_reached_o, 0);
    node.send(16'h0011, 555);
    step(3);
    chk("spd_m", speed_limit_o, SPD_MAN_RST);
    acc("goal", 0, IDX_GOAL, 0, 0, 0, 100);
    node.send(16'h0000, 0);
    step(3);
    chk("dis", {motion_enable_o, speed_limit_o}, {1'b0, SPD_POS_RST});
    start_phase_i = 1'b1;
    acc("trq_w", 1, IDX_TRQ_RUN, 0, 77, 0, 0);
    chk("trq_s", torque_limit_o, TRQ_START_RST);
    start_phase_i = 1'b0;
    step(2);
    chk("trq_r", torque_limit_o, 77);
  endtask
  task automatic t_errors;
    err_flags_i = 8'h04;
    acc("ereg", 0, IDX_ERR_REG, 0, 0, 0, 8'h05);
    acc("ereg_w", 1, IDX_ERR_REG, 0, 0, 1, 0);
    {err_event_i, err_code_i} = {1'b1, 32'haaaa};
    step(1);
    err_code_i = 32'hbbbb;
    step(1);
    err_event_i = 1'b0;
    acc("h0", 0, IDX_ERR_HIST, 0, 0, 0, 2);
    acc("h1", 0, IDX_ERR_HIST, 1, 0, 0, 32'hbbbb);
    acc("h2", 0, IDX_ERR_HIST, 2, 0, 0, 32'haaaa);
    acc("hclr", 1, IDX_ERR_HIST, 0, 0, 0, 0);
    acc("h1gone", 0, IDX_ERR_HIST, 1, 0, 1, 0);
  endtask
  task automatic t_reference;
    mech_pos_i = 1000;
    acc("ref_w", 1, IDX_CURRENT, 0, 50, 0, 0);
    acc("ref_r", 0, IDX_CURRENT, 0, 0, 0, 50);
    step(2);
    chk("tx_act", pdo_tx_data_o[63:32], 50);
    acc("ofs7", 1, IDX_OFFSET, 0, 7, 0, 0);
    comm_reset_i = 1'b1;
    step(1);
    comm_reset_i = 1'b0;
    acc("goal0", 0, IDX_GOAL, 0, 0, 0, 0);
    acc("ofs_kept", 0, IDX_OFFSET, 0, 0, 0, 7);
    chk("cmd_ofs", cmd_target_o, 32'hffff_fff9);
  endtask
  task automatic final_report;
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    #20000;
    err_count++;
    final_report();
  end
  initial begin
    {rst_n_i, comm_reset_i, standstill_i, start_phase_i, err_event_i} = '0;
    {mech_pos_i, traj_pos_i, err_code_i, err_flags_i} = '0;
    aux_word_i = 16'hc3a5;
    step(5);
    rst_n_i = 1'b1;
    t_defaults();
    t_protect();
    t_limits();
    t_motion();
    t_errors();
    t_reference();
    final_report();
  end
endmodule // drive_object_dictionary_tb
`default_nettype wire
